//--- design/cbr_pkg.sv
// Purpose: Constants and encodings shared by the charger control and status registers.
// Assumes: 8-bit registers on an 8-bit address, 25 MHz system clock.
// Notes:   All voltages are carried as 14-bit millivolt values.

package cbr_pkg;

	// ****************************************************************
	// Bus and register map
	// ****************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned MV_W   = 14;

	localparam logic [7:0] OFS_PROT_CTRL  = 8'h06;
	localparam logic [7:0] OFS_TRK_CTRL   = 8'h07;
	localparam logic [7:0] OFS_STATE_RPT  = 8'h08;
	localparam logic [7:0] OFS_REG_RESET  = 8'h0b;
	localparam logic [7:0] OFS_OFFSET_SEL = 8'h0f;

	localparam logic [7:0] RST_PROT_CTRL  = 8'he6;
	localparam logic [7:0] RST_TRK_CTRL   = 8'h4c;
	localparam logic [1:0] RST_OFFSET_SEL = 2'h0;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int unsigned POS_OVP_LO      = 6;
	localparam int unsigned POS_BOOST_LO    = 4;
	localparam int unsigned POS_VLIM_LO     = 0;
	localparam int unsigned POS_FORCE_DET   = 7;
	localparam int unsigned POS_HALF_RATE   = 6;
	localparam int unsigned POS_SW_DISABLE  = 5;
	localparam int unsigned POS_WARM_SEL    = 4;
	localparam int unsigned POS_SW_DELAY    = 3;
	localparam int unsigned POS_SW_RST_EN   = 2;
	localparam int unsigned POS_TRACK_LO    = 0;
	localparam int unsigned POS_REG_RESET   = 7;

	// ****************************************************************
	// Voltage tables in millivolts
	// ****************************************************************
	localparam logic [13:0] OVP_MV_0   = 14'h157c;
	localparam logic [13:0] OVP_MV_1   = 14'h1964;
	localparam logic [13:0] OVP_MV_2   = 14'h2904;
	localparam logic [13:0] OVP_MV_3   = 14'h36b0;
	localparam logic [13:0] BOOST_MV_0 = 14'h12f2;
	localparam logic [13:0] BOOST_MV_1 = 14'h1388;
	localparam logic [13:0] BOOST_MV_2 = 14'h141e;
	localparam logic [13:0] BOOST_MV_3 = 14'h14b4;
	localparam logic [13:0] VOFS_MV_0  = 14'h0f3c;
	localparam logic [13:0] VOFS_MV_1  = 14'h170c;
	localparam logic [13:0] VOFS_MV_2  = 14'h1d4c;
	localparam logic [13:0] VOFS_MV_3  = 14'h2904;
	localparam logic [13:0] VLIM_STEP_MV = 14'h0064;
	localparam logic [13:0] TRACK_MV_1 = 14'h00c8;
	localparam logic [13:0] TRACK_MV_2 = 14'h00fa;
	localparam logic [13:0] TRACK_MV_3 = 14'h012c;
	localparam logic [13:0] WARM_CAP_MV = 14'h1004;

	// ****************************************************************
	// Source status codes
	// ****************************************************************
	localparam logic [2:0] SRC_NONE  = 3'h0;
	localparam logic [2:0] SRC_SDP   = 3'h1;
	localparam logic [2:0] SRC_CDP   = 3'h2;
	localparam logic [2:0] SRC_DCP   = 3'h3;
	localparam logic [2:0] SRC_NSTD  = 3'h6;
	localparam logic [2:0] SRC_BOOST = 3'h7;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_HZ            = 32'h017d7840;
	localparam int unsigned SHIP_DELAY_S      = 32'h0000000c;
	localparam int unsigned SHIP_DELAY_CYCLES = SHIP_DELAY_S * CLK_HZ;
	localparam int unsigned SHIP_CNT_W        = 29;

endpackage

//--- design/cbr_ship_delay.sv
// Purpose: Shipping-mode delay counter for the battery switch.
// Assumes: run_i is held high for the whole wait.
// Notes:   done_o rises CYCLES edges after run_i rises and stays until run_i falls.

`timescale 1ns/1ps

module cbr_ship_delay #(
	parameter int unsigned CYCLES = 32'h11e1a300,
	parameter int unsigned CNT_W  = 29
) (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	output logic      done_o
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             done;
	} cbr_dly_state_t;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	cbr_dly_state_t s;
	cbr_dly_state_t next_s;

	always_comb begin
		next_s = s;
		if (!run_i) begin
			next_s.count = '0;
			next_s.done  = 1'b0;
		end else if (!s.done) begin
			if (s.count == LAST) begin
				next_s.done = 1'b1;
			end else begin
				next_s.count = s.count + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done_o = s.done;

endmodule

//--- design/cbr_regs.sv
// Purpose: Charger control and status registers with their decoded settings.
// Assumes: Status inputs and ticks are synchronous to sys_clk_i.
// Notes:   Decoded outputs follow a register write by two clock edges, battery_switch_on_o by three plus any shipping delay.

`timescale 1ns/1ps

module cbr_regs
	import cbr_pkg::*;
#(
	parameter int unsigned SHIP_CYCLES  = cbr_pkg::SHIP_DELAY_CYCLES,
	parameter bit          BASE_VARIANT = 1'b0
) (
	input  wire logic                          sys_clk_i,
	input  wire logic                          rst_i,
	input  wire logic [cbr_pkg::ADDR_W-1:0]    addr_i,
	input  wire logic [cbr_pkg::DATA_W-1:0]    wr_data_i,
	input  wire logic                          wr_en_i,
	input  wire logic                          rd_en_i,
	output logic      [cbr_pkg::DATA_W-1:0]    rd_data_o,
	input  wire logic [2:0]                    source_type_status_i,
	input  wire logic [1:0]                    charge_state_i,
	input  wire logic                          power_good_flag_i,
	input  wire logic                          thermal_limit_flag_i,
	input  wire logic                          min_system_voltage_flag_i,
	input  wire logic                          input_present_i,
	input  wire logic                          detection_done_i,
	input  wire logic                          dpm_active_i,
	input  wire logic                          cool_zone_i,
	input  wire logic                          warm_zone_i,
	input  wire logic [cbr_pkg::MV_W-1:0]      battery_mv_i,
	input  wire logic [cbr_pkg::MV_W-1:0]      charge_target_mv_i,
	input  wire logic                          timer_tick_i,
	output logic [cbr_pkg::MV_W-1:0]           input_overvolt_threshold_mv_o,
	output logic [cbr_pkg::MV_W-1:0]           boost_output_level_mv_o,
	output logic [cbr_pkg::MV_W-1:0]           input_voltage_limit_mv_o,
	output logic [cbr_pkg::MV_W-1:0]           charge_voltage_limit_mv_o,
	output logic                               force_input_detection_o,
	output logic                               safety_tick_o,
	output logic                               safety_timer_reset_o,
	output logic                               battery_switch_on_o,
	output logic                               battery_switch_reset_allow_o
);

	import cbr_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic [2:0] {
		SW_ON   = 3'h1,
		SW_WAIT = 3'h2,
		SW_OFF  = 3'h4
	} cbr_sw_state_t;

	typedef struct packed {
		logic [7:0]      prot_ctrl;
		logic [7:0]      trk_ctrl;
		logic [1:0]      offset_sel;
		logic [7:0]      rd_data;
		cbr_sw_state_t   sw_state;
		logic            tick_phase;
		logic            safety_tick;
		logic            timer_reset;
		logic [13:0]     ovp_mv;
		logic [13:0]     boost_mv;
		logic [13:0]     vlim_mv;
		logic [13:0]     chg_mv;
		logic            force_det;
		logic            sw_on;
		logic            sw_rst_allow;
	} cbr_state_t;

	cbr_state_t s;
	cbr_state_t next_s;
	logic       ship_done;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	function automatic logic [13:0] max_mv(input logic [13:0] a, input logic [13:0] b);
		max_mv = (a > b) ? a : b;
	endfunction

	function automatic logic [13:0] min_mv(input logic [13:0] a, input logic [13:0] b);
		min_mv = (a < b) ? a : b;
	endfunction

	function automatic logic [13:0] ovp_decode(input logic [1:0] code);
		unique case (code)
			2'h0: ovp_decode = OVP_MV_0;
			2'h1: ovp_decode = OVP_MV_1;
			2'h2: ovp_decode = OVP_MV_2;
			2'h3: ovp_decode = OVP_MV_3;
		endcase
	endfunction

	function automatic logic [13:0] boost_decode(input logic [1:0] code);
		unique case (code)
			2'h0: boost_decode = BOOST_MV_0;
			2'h1: boost_decode = BOOST_MV_1;
			2'h2: boost_decode = BOOST_MV_2;
			2'h3: boost_decode = BOOST_MV_3;
		endcase
	endfunction

	function automatic logic [13:0] offset_decode(input logic [1:0] sel);
		unique case (sel)
			2'h0: offset_decode = VOFS_MV_0;
			2'h1: offset_decode = VOFS_MV_1;
			2'h2: offset_decode = VOFS_MV_2;
			2'h3: offset_decode = VOFS_MV_3;
		endcase
	endfunction

	function automatic logic [13:0] track_decode(input logic [1:0] code,
			input logic [13:0] vbat);
		unique case (code)
			2'h0: track_decode = 14'h0000;
			2'h1: track_decode = 14'(vbat + TRACK_MV_1);
			2'h2: track_decode = 14'(vbat + TRACK_MV_2);
			2'h3: track_decode = 14'(vbat + TRACK_MV_3);
		endcase
	endfunction

	// Codes other than none, SDP, CDP and boost read as no input on the base variant
	function automatic logic [2:0] source_report(input logic [2:0] code);
		if (!BASE_VARIANT) begin
			source_report = code;
		end else if (code == SRC_NONE || code == SRC_SDP || code == SRC_CDP ||
				code == SRC_BOOST) begin
			source_report = code;
		end else begin
			source_report = SRC_NONE;
		end
	endfunction

	// ****************************************************************
	// Shipping delay
	// ****************************************************************
	cbr_ship_delay #(
		.CYCLES (SHIP_CYCLES),
		.CNT_W  (SHIP_CNT_W)
	) u_ship_delay (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.run_i     (s.sw_state == SW_WAIT),
		.done_o    (ship_done)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [13:0] prog_mv;
		logic [13:0] track_mv;
		logic        half_rate;
		logic        force_set;
		logic        sw_disable;
		logic        sw_delay;
		prog_mv    = 14'h0000;
		track_mv   = 14'h0000;
		half_rate  = 1'b0;
		force_set  = 1'b0;
		sw_disable = 1'b0;
		sw_delay   = 1'b0;

		next_s             = s;
		next_s.rd_data     = 8'h00;
		next_s.safety_tick = 1'b0;
		next_s.timer_reset = 1'b0;

		// Register reads, no side effects
		if (rd_en_i) begin
			unique case (addr_i)
				OFS_PROT_CTRL:  next_s.rd_data = s.prot_ctrl;
				OFS_TRK_CTRL:   next_s.rd_data = s.trk_ctrl;
				OFS_STATE_RPT:  next_s.rd_data = {source_report(source_type_status_i),
						charge_state_i,
						power_good_flag_i,
						thermal_limit_flag_i,
						min_system_voltage_flag_i};
				OFS_REG_RESET:  next_s.rd_data = 8'h00;
				OFS_OFFSET_SEL: next_s.rd_data = {6'h00, s.offset_sel};
				default:        next_s.rd_data = 8'h00;
			endcase
		end

		// Register writes; the status register has no write path
		if (wr_en_i) begin
			unique case (addr_i)
				OFS_PROT_CTRL: begin
					next_s.prot_ctrl = wr_data_i;
				end
				OFS_TRK_CTRL: begin
					next_s.trk_ctrl = wr_data_i;
					// Detection request only taken while input is present
					force_set = wr_data_i[POS_FORCE_DET] && input_present_i;
					next_s.trk_ctrl[POS_FORCE_DET] = force_set;
				end
				OFS_OFFSET_SEL: begin
					next_s.offset_sel = wr_data_i[1:0];
				end
				OFS_REG_RESET: begin
					if (wr_data_i[POS_REG_RESET]) begin
						// Self-clearing: bit never stays set
						next_s.prot_ctrl   = RST_PROT_CTRL;
						next_s.trk_ctrl    = RST_TRK_CTRL;
						next_s.offset_sel  = RST_OFFSET_SEL;
						next_s.timer_reset = 1'b1;
						next_s.tick_phase  = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Detection end clears the bit unless a new request lands now
		if (detection_done_i && !force_set) begin
			next_s.trk_ctrl[POS_FORCE_DET] = 1'b0;
		end

		// Safety timer rate
		half_rate = s.trk_ctrl[POS_HALF_RATE] &&
				(dpm_active_i || cool_zone_i || thermal_limit_flag_i);
		if (s.timer_reset) begin
			next_s.tick_phase = 1'b0;
		end else if (timer_tick_i) begin
			if (half_rate) begin
				next_s.safety_tick = s.tick_phase;
				next_s.tick_phase  = ~s.tick_phase;
			end else begin
				next_s.safety_tick = 1'b1;
				next_s.tick_phase  = 1'b0;
			end
		end

		// Battery switch control
		sw_disable = s.trk_ctrl[POS_SW_DISABLE];
		sw_delay   = s.trk_ctrl[POS_SW_DELAY];
		unique case (s.sw_state)
			SW_ON: begin
				if (sw_disable && sw_delay) begin
					next_s.sw_state = SW_WAIT;
				end else if (sw_disable) begin
					next_s.sw_state = SW_OFF;
				end
			end
			SW_WAIT: begin
				if (!sw_disable) begin
					next_s.sw_state = SW_ON;
				end else if (!sw_delay || ship_done) begin
					next_s.sw_state = SW_OFF;
				end
			end
			SW_OFF: begin
				if (!sw_disable) begin
					next_s.sw_state = SW_ON;
				end
			end
			default: begin
				next_s.sw_state = SW_ON;
			end
		endcase

		// Decoded settings
		next_s.ovp_mv   = ovp_decode(s.prot_ctrl[POS_OVP_LO +: 2]);
		next_s.boost_mv = boost_decode(s.prot_ctrl[POS_BOOST_LO +: 2]);
		prog_mv = 14'(offset_decode(s.offset_sel) +
				14'(s.prot_ctrl[POS_VLIM_LO +: 4] * VLIM_STEP_MV));
		track_mv = track_decode(s.trk_ctrl[POS_TRACK_LO +: 2], battery_mv_i);
		next_s.vlim_mv = max_mv(prog_mv, track_mv);
		if (warm_zone_i && !s.trk_ctrl[POS_WARM_SEL]) begin
			next_s.chg_mv = min_mv(WARM_CAP_MV, charge_target_mv_i);
		end else begin
			next_s.chg_mv = charge_target_mv_i;
		end
		next_s.force_det    = s.trk_ctrl[POS_FORCE_DET] && input_present_i;
		next_s.sw_on        = (s.sw_state != SW_OFF);
		next_s.sw_rst_allow = s.trk_ctrl[POS_SW_RST_EN];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s              <= '0;
			s.prot_ctrl    <= RST_PROT_CTRL;
			s.trk_ctrl     <= RST_TRK_CTRL;
			s.offset_sel   <= RST_OFFSET_SEL;
			s.sw_state     <= SW_ON;
			s.ovp_mv       <= OVP_MV_3;
			s.boost_mv     <= BOOST_MV_2;
			s.vlim_mv      <= 14'h1194;
			s.sw_on        <= 1'b1;
			s.sw_rst_allow <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rd_data_o                     = s.rd_data;
	assign input_overvolt_threshold_mv_o = s.ovp_mv;
	assign boost_output_level_mv_o       = s.boost_mv;
	assign input_voltage_limit_mv_o      = s.vlim_mv;
	assign charge_voltage_limit_mv_o     = s.chg_mv;
	assign force_input_detection_o       = s.force_det;
	assign safety_tick_o                 = s.safety_tick;
	assign safety_timer_reset_o          = s.timer_reset;
	assign battery_switch_on_o           = s.sw_on;
	assign battery_switch_reset_allow_o  = s.sw_rst_allow;

endmodule

//--- test/cbr_regs_chk.sv
// Purpose: Port-level assertions for the charger control and status registers.
// Assumes: Bound to cbr_regs; one clock domain; reset active high.
// Notes:   Decoded outputs are checked two edges after the write edge.
`timescale 1ns/1ps
module cbr_regs_chk
	import cbr_pkg::*;
#(
	parameter int unsigned SHIP_CYCLES = 20
) (
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  addr_i,
	input wire logic [7:0]  wr_data_i,
	input wire logic        wr_en_i,
	input wire logic        rd_en_i,
	input wire logic [7:0]  rd_data_o,
	input wire logic [2:0]  source_type_status_i,
	input wire logic [1:0]  charge_state_i,
	input wire logic        power_good_flag_i,
	input wire logic        thermal_limit_flag_i,
	input wire logic        min_system_voltage_flag_i,
	input wire logic        input_present_i,
	input wire logic        detection_done_i,
	input wire logic        dpm_active_i,
	input wire logic        cool_zone_i,
	input wire logic        timer_tick_i,
	input wire logic [13:0] input_overvolt_threshold_mv_o,
	input wire logic        force_input_detection_o,
	input wire logic        safety_tick_o,
	input wire logic        safety_timer_reset_o,
	input wire logic        battery_switch_reset_allow_o
);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	localparam logic [13:0] OVP_T [4] = '{OVP_MV_0, OVP_MV_1, OVP_MV_2, OVP_MV_3};
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_wr(logic [7:0] a);
		wr_en_i && addr_i == a;
	endsequence
	sequence s_det_done;
		detection_done_i && !wr_en_i;
	endsequence
	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_rd_idle_zero: assert property (!rd_en_i |=> rd_data_o == 8'h00)
		else $error("read data not idle");
	a_status_live: assert property (rd_en_i && addr_i == OFS_STATE_RPT |=> rd_data_o ==
		$past({source_type_status_i, charge_state_i, power_good_flag_i,
		thermal_limit_flag_i, min_system_voltage_flag_i}))
		else $error("status read wrong");
	a_ovp_decode: assert property (s_wr(OFS_PROT_CTRL) |-> ##2
		input_overvolt_threshold_mv_o == OVP_T[$past(wr_data_i[7:6], 2)])
		else $error("threshold decode wrong");
	a_tick_full_rate: assert property (timer_tick_i && !dpm_active_i && !cool_zone_i
		&& !thermal_limit_flag_i |=> safety_tick_o)
		else $error("tick dropped");
	a_tick_has_cause: assert property (safety_tick_o |-> $past(timer_tick_i))
		else $error("spurious tick");
	a_det_gated: assert property (force_input_detection_o |-> $past(input_present_i))
		else $error("detection without input");
	a_det_cleared: assert property (s_det_done |-> ##2 !force_input_detection_o)
		else $error("detection not cleared");
	a_allow_follows: assert property (s_wr(OFS_TRK_CTRL) |-> ##2
		battery_switch_reset_allow_o == $past(wr_data_i[2], 2))
		else $error("reset allow wrong");
	a_timer_reset: assert property (s_wr(OFS_REG_RESET) ##0 wr_data_i[7] |->
		##[1:2] safety_timer_reset_o)
		else $error("timer reset missing");
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the charger control and status registers.
// Assumes: Short shipping delay of 20 cycles.
// Notes:   Register bus driven with one-cycle strobes.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %0t got %h want %h", $time, (g), (e)); end end
module tb_top;
	import cbr_pkg::*;
	localparam int unsigned SHIP = 20;
	logic        sys_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [7:0]  wr_data_i = 8'h00;
	logic        wr_en_i = 1'b0;
	logic        rd_en_i = 1'b0;
	logic [2:0]  source_type_status_i = 3'h0;
	logic [1:0]  charge_state_i = 2'h0;
	logic        power_good_flag_i = 1'b0;
	logic        thermal_limit_flag_i = 1'b0;
	logic        min_system_voltage_flag_i = 1'b0;
	logic        input_present_i = 1'b0;
	logic        detection_done_i = 1'b0;
	logic        dpm_active_i = 1'b0;
	logic        cool_zone_i = 1'b0;
	logic        warm_zone_i = 1'b0;
	logic [13:0] battery_mv_i = 14'h0000;
	logic [13:0] charge_target_mv_i = 14'h1068;
	logic        timer_tick_i = 1'b0;
	logic [7:0]  rd_data_o;
	logic [13:0] input_overvolt_threshold_mv_o, boost_output_level_mv_o;
	logic [13:0] input_voltage_limit_mv_o, charge_voltage_limit_mv_o;
	logic        force_input_detection_o, safety_tick_o, safety_timer_reset_o;
	logic        battery_switch_on_o, battery_switch_reset_allow_o;
	int          err_total = 0;
	int          n_checks = 0;
	int          tick_cnt = 0;
	int          trst_cnt = 0;
	int          n;
	logic [13:0] ovp_t [4] = '{OVP_MV_0, OVP_MV_1, OVP_MV_2, OVP_MV_3};
	logic [13:0] bst_t [4] = '{BOOST_MV_0, BOOST_MV_1, BOOST_MV_2, BOOST_MV_3};
	logic [13:0] ofs_t [4] = '{VOFS_MV_0, VOFS_MV_1, VOFS_MV_2, VOFS_MV_3};
	logic [13:0] trk_t [4] = '{VOFS_MV_0, 14'h1450, 14'h1482, 14'h14b4};
	logic [2:0]  src_t [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

	cbr_regs #(.SHIP_CYCLES(SHIP), .BASE_VARIANT(1'b0)) DUT (.sys_clk_i, .rst_i, .addr_i,
		.wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .source_type_status_i, .charge_state_i,
		.power_good_flag_i, .thermal_limit_flag_i, .min_system_voltage_flag_i,
		.input_present_i, .detection_done_i, .dpm_active_i, .cool_zone_i, .warm_zone_i,
		.battery_mv_i, .charge_target_mv_i, .timer_tick_i, .input_overvolt_threshold_mv_o,
		.boost_output_level_mv_o, .input_voltage_limit_mv_o, .charge_voltage_limit_mv_o,
		.force_input_detection_o, .safety_tick_o, .safety_timer_reset_o,
		.battery_switch_on_o, .battery_switch_reset_allow_o);

	always #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		tick_cnt += (safety_tick_o === 1'b1);
		trst_cnt += (safety_timer_reset_o === 1'b1);
	end

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_en_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_en_i <= 1'b0;
		#1;
		`CHK(rd_data_o, e)
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic ticks(input int e);
		#1;
		tick_cnt = 0;
		repeat (4) begin
			@(posedge sys_clk_i);
			timer_tick_i <= 1'b1;
			@(posedge sys_clk_i);
			timer_tick_i <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
		end
		settle();
		`CHK(tick_cnt, e)
	endtask
	task automatic report_and_stop;
		if (err_total == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_total++;
		report_and_stop();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		rdc(OFS_PROT_CTRL, 8'he6);
		rdc(OFS_TRK_CTRL, 8'h4c);
		rdc(OFS_OFFSET_SEL, 8'h00);
		`CHK(input_voltage_limit_mv_o, 14'h1194)
		`CHK(boost_output_level_mv_o, BOOST_MV_2)
		`CHK(battery_switch_on_o, 1'b1)
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PROT_CTRL, {4{i[1:0]}});
			wr(OFS_OFFSET_SEL, {6'h00, i[1:0]});
			settle();
			`CHK(input_overvolt_threshold_mv_o, ovp_t[i])
			`CHK(boost_output_level_mv_o, bst_t[i])
			`CHK(input_voltage_limit_mv_o, ofs_t[i] + 14'(i * 5) * VLIM_STEP_MV)
		end
		wr(OFS_PROT_CTRL, 8'he0);
		wr(OFS_OFFSET_SEL, 8'h00);
		battery_mv_i <= 14'h1388;
		for (int t = 0; t < 4; t++) begin
			wr(OFS_TRK_CTRL, {6'h13, t[1:0]});
			settle();
			`CHK(input_voltage_limit_mv_o, trk_t[t])
		end
		battery_mv_i <= 14'h0bb8;
		settle();
		`CHK(input_voltage_limit_mv_o, VOFS_MV_0)
		wr(OFS_TRK_CTRL, 8'h4c);
		warm_zone_i <= 1'b1;
		settle();
		`CHK(charge_voltage_limit_mv_o, WARM_CAP_MV)
		wr(OFS_TRK_CTRL, 8'h5c);
		settle();
		`CHK(charge_voltage_limit_mv_o, 14'h1068)
		wr(OFS_TRK_CTRL, 8'h4c);
		charge_target_mv_i <= 14'h0fa0;
		settle();
		`CHK(charge_voltage_limit_mv_o, 14'h0fa0)
		for (int i = 0; i < 6; i++) begin
			source_type_status_i <= src_t[i];
			charge_state_i <= i[1:0];
			power_good_flag_i <= i[0];
			thermal_limit_flag_i <= i[1];
			min_system_voltage_flag_i <= i[2];
			rdc(OFS_STATE_RPT, {src_t[i], i[1:0], i[0], i[1], i[2]});
		end
		wr(OFS_STATE_RPT, 8'h00);
		rdc(OFS_STATE_RPT, 8'hed);
		rdc(8'h20, 8'h00);
		thermal_limit_flag_i <= 1'b0;
		min_system_voltage_flag_i <= 1'b0;
		wr(OFS_TRK_CTRL, 8'hcc);
		rdc(OFS_TRK_CTRL, 8'h4c);
		input_present_i <= 1'b1;
		wr(OFS_TRK_CTRL, 8'hcc);
		settle();
		`CHK(force_input_detection_o, 1'b1)
		detection_done_i <= 1'b1;
		@(posedge sys_clk_i);
		detection_done_i <= 1'b0;
		settle();
		`CHK(force_input_detection_o, 1'b0)
		rdc(OFS_TRK_CTRL, 8'h4c);
		wr(OFS_TRK_CTRL, 8'h64);
		settle();
		`CHK(battery_switch_on_o, 1'b0)
		wr(OFS_TRK_CTRL, 8'h4c);
		settle();
		`CHK(battery_switch_on_o, 1'b1)
		wr(OFS_TRK_CTRL, 8'h6c);
		n = 0;
		while (battery_switch_on_o === 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		if (n == 100) begin
			err_total++;
			report_and_stop();
		end
		`CHK(n >= SHIP && n <= SHIP + 5, 1'b1)
		wr(OFS_TRK_CTRL, 8'h4c);
		wr(OFS_TRK_CTRL, 8'h6c);
		wr(OFS_TRK_CTRL, 8'h64);
		settle();
		`CHK(battery_switch_on_o, 1'b0)
		wr(OFS_TRK_CTRL, 8'h08);
		settle();
		`CHK(battery_switch_reset_allow_o, 1'b0)
		wr(OFS_PROT_CTRL, 8'h00);
		wr(OFS_OFFSET_SEL, 8'h03);
		#1;
		trst_cnt = 0;
		wr(OFS_REG_RESET, 8'h80);
		settle();
		`CHK(trst_cnt, 1)
		rdc(OFS_PROT_CTRL, 8'he6);
		rdc(OFS_TRK_CTRL, 8'h4c);
		rdc(OFS_OFFSET_SEL, 8'h00);
		rdc(OFS_REG_RESET, 8'h00);
		`CHK(battery_switch_on_o, 1'b1)
		ticks(4);
		dpm_active_i <= 1'b1;
		ticks(2);
		dpm_active_i <= 1'b0;
		cool_zone_i <= 1'b1;
		ticks(2);
		wr(OFS_TRK_CTRL, 8'h0c);
		ticks(4);
		report_and_stop();
	end
endmodule

bind cbr_regs cbr_regs_chk #(.SHIP_CYCLES(SHIP_CYCLES)) u_chk (.sys_clk_i, .rst_i, .addr_i,
	.wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .source_type_status_i, .charge_state_i,
	.power_good_flag_i, .thermal_limit_flag_i, .min_system_voltage_flag_i, .input_present_i,
	.detection_done_i, .dpm_active_i, .cool_zone_i, .timer_tick_i,
	.input_overvolt_threshold_mv_o, .force_input_detection_o, .safety_tick_o,
	.safety_timer_reset_o, .battery_switch_reset_allow_o);
